// ---- rtl/hxs_regs.sv ----
// Transfer setup register bank on APB.
// Assumes card engine gives transfer status and block pulses on pclk.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module hxs_regs
   import hxs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        data_line_cmd_block,
   input  wire logic        xfer_active,
   input  wire logic        block_done,
   input  wire logic        cmd_complete,
   input  wire logic        cmd_complete_sig_en,
   output logic [31:0]      cmd_frame_arg,
   output logic             dma_en,
   output logic             blk_cnt_en,
   output logic [1:0]       auto_cmd_en,
   output logic             dir_read,
   output logic             multi_block,
   output logic             resp_check_type_sel,
   output logic             resp_check_en,
   output logic             resp_int_dis,
   output logic             xfer_stop,
   output logic             cmd_complete_irq
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic [31:0] arg_q;
   logic [15:0] xmode_q;
   logic [15:0] cnt_val;
   logic        cnt_zero;
   logic        stop_q;
   logic        irq_q;
   logic [31:0] rdata_q;
   logic        err_q;

   wire acc      = psel & penable;
   wire setup    = psel & ~penable;
   wire sel_cnt  = (paddr == HXS_OFF_BLK_CNT);
   wire sel_arg  = (paddr == HXS_OFF_ARG);
   wire sel_xm   = (paddr == HXS_OFF_XMODE);
   wire mapped   = sel_cnt | sel_arg | sel_xm;
   wire wr_acc   = acc & pwrite;
   wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                        {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [31:0] wmerge_arg = (arg_q & ~bmask) | (pwdata & bmask);
   wire [15:0] wmerge_xm  = (xmode_q & ~bmask[15:0])
                            | (pwdata[15:0] & bmask[15:0]);

   // (R1) count write dropped in transfer
   wire cnt_wr   = wr_acc & sel_cnt & ~xfer_active;
   // (R6) mode write protected
   wire xm_wr    = wr_acc & sel_xm & ~data_line_cmd_block;
   wire arg_wr   = wr_acc & sel_arg;
   wire [15:0] cnt_load_val = (cnt_val & ~bmask[15:0])
                              | (pwdata[15:0] & bmask[15:0]);

   // (R11) reserved bits dropped
   wire [15:0] xmode_d = xm_wr ? (wmerge_xm & HXS_XM_MASK) : xmode_q;
   // (R3) full argument stored
   wire [31:0] arg_d   = arg_wr ? wmerge_arg : arg_q;

   wire [31:0] rd_mux = sel_cnt ? {16'h0000, cnt_val} :
                        sel_arg ? arg_q :
                        sel_xm  ? {16'h0000, xmode_q} : 32'h0000_0000;

   // ----------------------------------------
   // Block counter
   // ----------------------------------------
   // (R9) counts only when enabled and multi
   wire cnt_use = xmode_q[HXS_XM_CNT_EN] & xmode_q[HXS_XM_MULTI];

   hxs_block_counter u_cnt (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (cnt_wr),
      .load_val   (cnt_load_val),
      .count_en   (cnt_use & xfer_active),
      .block_done (block_done),
      .count_q    (cnt_val),
      .at_zero    (cnt_zero)
   );

   // (R8) stop at zero count
   wire stop_d = cnt_use & xfer_active & cnt_zero;
   // (R10) response interrupt disable gate
   wire irq_d  = cmd_complete & cmd_complete_sig_en
                 & ~xmode_q[HXS_XM_RINT_DIS];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg_q   <= HXS_RST_ARG;
         xmode_q <= HXS_RST_XMODE;
      end else begin
         arg_q   <= arg_d;
         xmode_q <= xmode_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         stop_q <= stop_d;
         irq_q  <= irq_d;
      end
   end

   // Answer in the access cycle, data latched at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else if (setup) begin
         rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         err_q   <= ~mapped;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata              = rdata_q;
   assign pready              = 1'b1;
   assign pslverr             = err_q;
   assign cmd_frame_arg       = arg_q;
   assign dma_en              = xmode_q[HXS_XM_DMA];
   assign blk_cnt_en          = xmode_q[HXS_XM_CNT_EN];
   // (R7) field layout
   assign auto_cmd_en         = xmode_q[HXS_XM_ACMD_LO +: 2];
   assign dir_read            = xmode_q[HXS_XM_DIR];
   assign multi_block         = xmode_q[HXS_XM_MULTI];
   assign resp_check_type_sel = xmode_q[HXS_XM_RTYPE];
   assign resp_check_en       = xmode_q[HXS_XM_RCHK];
   assign resp_int_dis        = xmode_q[HXS_XM_RINT_DIS];
   assign xfer_stop           = stop_q;
   assign cmd_complete_irq    = irq_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // (R6) protected write check
   xm_prot_a: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
      wr_acc && sel_xm && data_line_cmd_block |=> xmode_q == $past(xmode_q))
      else $error("transfer mode changed while protected");
   // (R1) count write drop check
   cnt_prot_a: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
      wr_acc && sel_cnt && xfer_active && !block_done
      |=> cnt_val == $past(cnt_val))
      else $error("block count written during transfer");
   // (R11) reserved zero check
   rsvd_zero_a: assert property (@(posedge pclk) // (R11)
      disable iff (!presetn) xmode_q[15:9] == 7'h00)
      else $error("reserved transfer mode bits set");
   // (R3) argument to frame
   arg_frame_a: assert property (@(posedge pclk) disable iff (!presetn) // (R3)
      arg_wr && pstrb == 4'hF |=> cmd_frame_arg == $past(pwdata))
      else $error("argument not presented to frame");
   // (R10) suppressed interrupt
   irq_sup_a: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
      xmode_q[HXS_XM_RINT_DIS] |=> !cmd_complete_irq)
      else $error("command complete raised while disabled");
   // (R8) stop follows zero
   stop_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
      cnt_use && xfer_active && cnt_zero |=> xfer_stop)
      else $error("transfer not stopped at zero count");
   // (R9) counter idle unless enabled
   cnt_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
      !cnt_use && !cnt_wr |=> $stable(cnt_val))
      else $error("counter moved while not in use");
   // (R7) mode write lands
   xm_write_a: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
      wr_acc && sel_xm && !data_line_cmd_block && pstrb == 4'hF
      |=> xmode_q == ($past(pwdata[15:0]) & 16'h01FF))
      else $error("transfer mode write lost");

   // ----------------------------------------
   // Bus answer checks
   // ----------------------------------------
   // Unmapped read is zero
   rd_zero_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && !mapped |=> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");
   // Unmapped access error
   slverr_unmap_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && !mapped |=> pslverr)
      else $error("unmapped access without error");
   // Mapped access no error
   slverr_map_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && mapped |=> !pslverr)
      else $error("mapped access flagged as error");
   // Write returns zero data
   rd_wr_zero_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && pwrite |=> prdata == 32'h0000_0000)
      else $error("write returned read data");
   // Answer held between setups
   rd_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !setup |=> $stable(prdata) && $stable(pslverr))
      else $error("read answer changed outside setup");
   // (R3) argument read back
   rd_arg_a: assert property (@(posedge pclk) // (R3)
      disable iff (!presetn)
      setup && !pwrite && sel_arg |=> prdata == $past(arg_q))
      else $error("argument read data wrong");
   // (R2) count read back
   rd_cnt_a: assert property (@(posedge pclk) // (R2)
      disable iff (!presetn)
      setup && !pwrite && sel_cnt |=> prdata == {16'h0000, $past(cnt_val)})
      else $error("block count read data wrong");
   // (R11) mode read back
   rd_xm_a: assert property (@(posedge pclk) // (R11)
      disable iff (!presetn)
      setup && !pwrite && sel_xm |=> prdata == {16'h0000, $past(xmode_q)})
      else $error("transfer mode read data wrong");

   // ----------------------------------------
   // Counter and stop checks
   // ----------------------------------------
   // (R2) count write lands
   cnt_load_a: assert property (@(posedge pclk) // (R2)
      disable iff (!presetn)
      cnt_wr && pstrb[1:0] == 2'h3 |=> cnt_val == $past(pwdata[15:0]))
      else $error("block count write lost");
   // (R2) zero holds
   cnt_floor_a: assert property (@(posedge pclk) // (R2)
      disable iff (!presetn)
      cnt_zero && !cnt_wr |=> cnt_zero)
      else $error("block count wrapped below zero");
   // (R8) never counts up
   cnt_no_up_a: assert property (@(posedge pclk) // (R8)
      disable iff (!presetn)
      !cnt_wr |=> cnt_val <= $past(cnt_val))
      else $error("block count rose without write");
   // (R8) one step per block
   cnt_step_a: assert property (@(posedge pclk) // (R8)
      disable iff (!presetn)
      cnt_use && xfer_active && block_done && !cnt_zero
      |=> cnt_val == $past(cnt_val) - 16'h0001)
      else $error("block count missed a block");
   // (R9) single block idle
   cnt_single_a: assert property (@(posedge pclk) // (R9)
      disable iff (!presetn)
      !multi_block && !cnt_wr |=> $stable(cnt_val))
      else $error("block count moved on single block");
   // (R1) held during transfer
   cnt_busy_a: assert property (@(posedge pclk) // (R1)
      disable iff (!presetn)
      xfer_active && !(cnt_use && block_done) |=> $stable(cnt_val))
      else $error("block count changed during transfer");
   // (R8) stop only at zero
   stop_clear_a: assert property (@(posedge pclk) // (R8)
      disable iff (!presetn)
      !(cnt_use && xfer_active && cnt_zero) |=> !xfer_stop)
      else $error("transfer stop without zero count");
   // (R9) stop needs transfer
   stop_need_a: assert property (@(posedge pclk) // (R9)
      disable iff (!presetn)
      !xfer_active |=> !xfer_stop)
      else $error("transfer stop while idle");

   // ----------------------------------------
   // Mode and interrupt checks
   // ----------------------------------------
   // (R10) interrupt passes
   irq_pass_a: assert property (@(posedge pclk) // (R10)
      disable iff (!presetn)
      cmd_complete && cmd_complete_sig_en && !resp_int_dis
      |=> cmd_complete_irq)
      else $error("command complete interrupt lost");
   // (R10) signal enable gate
   irq_sig_a: assert property (@(posedge pclk) // (R10)
      disable iff (!presetn)
      !cmd_complete || !cmd_complete_sig_en |=> !cmd_complete_irq)
      else $error("command complete interrupt without cause");
   // (R6) mode frozen when blocked
   xm_dblk_a: assert property (@(posedge pclk) // (R6)
      disable iff (!presetn)
      data_line_cmd_block |=> $stable(xmode_q))
      else $error("transfer mode changed while blocked");
   // (R7) dma bit position
   xm_dma_a: assert property (@(posedge pclk) // (R7)
      disable iff (!presetn)
      xm_wr && pstrb[0] |=> dma_en == $past(pwdata[HXS_XM_DMA]))
      else $error("dma enable field misplaced");
   // (R7) auto command field
   xm_acmd_a: assert property (@(posedge pclk) // (R7)
      disable iff (!presetn)
      xm_wr && pstrb[0] |=> auto_cmd_en == $past(pwdata[HXS_XM_ACMD_LO +: 2]))
      else $error("auto command field misplaced");
   // (R7) interrupt disable field
   xm_rint_a: assert property (@(posedge pclk) // (R7)
      disable iff (!presetn)
      xm_wr && pstrb[1] |=> resp_int_dis == $past(pwdata[HXS_XM_RINT_DIS]))
      else $error("response interrupt disable misplaced");
endmodule

// ---- rtl/hxs_pkg.sv ----
// Constants for the transfer setup register bank.
// Assumes an APB master on pclk and a card engine beside the bank.
//
// Operation
// (R1) Block count writes dropped during a transfer; reads then unreliable.
// (R2) Block count is blocks remaining, 1 to 65535; zero means stop.
// (R3) 32-bit argument register feeds command frame bits 39 down to 8.
// (R4) Software programs transfer mode before data or resume commands.
// (R5) Software saves transfer mode on suspend, restores it before resume.
// (R6) Transfer mode writes ignored while data line command block is 1.
// (R7) Mode fields: dma, count en, auto cmd, dir, multi, resp bits.
// (R8) Counter decrements per finished block; transfer stops at zero.
// (R9) Counter used only with count enable set on multi-block transfers.
// (R10) Response interrupt disable suppresses command complete interrupt.
// (R11) Transfer mode bits 15 to 9 read zero and ignore writes.
package hxs_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [11:0] HXS_OFF_BLK_CNT = 12'h004;
   localparam logic [11:0] HXS_OFF_ARG     = 12'h008;
   localparam logic [11:0] HXS_OFF_XMODE   = 12'h00C;
   // ----------------------------------------
   // Transfer mode fields
   // ----------------------------------------
   localparam int HXS_XM_DMA      = 0;
   localparam int HXS_XM_CNT_EN   = 1;
   localparam int HXS_XM_ACMD_LO  = 2;
   localparam int HXS_XM_DIR      = 4;
   localparam int HXS_XM_MULTI    = 5;
   localparam int HXS_XM_RTYPE    = 6;
   localparam int HXS_XM_RCHK     = 7;
   localparam int HXS_XM_RINT_DIS = 8;
   localparam logic [15:0] HXS_XM_MASK = 16'h01FF;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] HXS_RST_BLK_CNT = 16'h0000;
   localparam logic [31:0] HXS_RST_ARG     = 32'h0000_0000;
   localparam logic [15:0] HXS_RST_XMODE   = 16'h0000;
   localparam logic [15:0] HXS_CNT_STOP    = 16'h0000;
endpackage

// ---- rtl/hxs_block_counter.sv ----
// Remaining block counter for one transfer.
// Assumes block_done pulses once per finished block, on pclk.
`timescale 1ns/1ps
module hxs_block_counter
   import hxs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic        count_en,
   input  wire logic        block_done,
   output logic [15:0]      count_q,
   output logic             at_zero
);
   logic [15:0] count_d;
   wire         dec = count_en & block_done & (count_q != HXS_CNT_STOP);

   // (R8) decrement per block
   assign count_d = load ? load_val : (dec ? count_q - 16'h0001 : count_q);
   // (R2) zero is stop count
   assign at_zero = (count_q == HXS_CNT_STOP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= HXS_RST_BLK_CNT;
      end else begin
         count_q <= count_d;
      end
   end

   // (R8) decrement checked
   cnt_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
      dec && !load |=> count_q == $past(count_q) - 16'h0001)
      else $error("block counter did not decrement");
endmodule

// ---- testbench/hxs_card_model.sv ----
// Card side model: transfer status, block pulses, command done.
// Assumes the bench drives run and fire just after pclk rising edges.
`timescale 1ns/1ps
module hxs_card_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   input  wire logic fire,
   output logic      xfer_active,
   output logic      data_line_cmd_block,
   output logic      block_done,
   output logic      cmd_complete
);
   logic [3:0] gap_q;
   // Data lines held busy for the whole transfer
   assign data_line_cmd_block = xfer_active;
   // One block every sixteen cycles while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {xfer_active, block_done, cmd_complete, gap_q} <= '0;
      end else begin
         xfer_active  <= run;
         cmd_complete <= fire;
         gap_q        <= run ? gap_q + 4'h1 : 4'h0;
         block_done   <= run && gap_q == 4'hF;
      end
   end
endmodule

// ---- testbench/test_host_xfer_setup_regs.sv ----
// Self-checking bench for the transfer setup register bank.
// Assumes an APB master here and the card model on the far side.
`timescale 1ns/1ps
module test_host_xfer_setup_regs
   import hxs_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, run, fire, sig_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, farg, saved;
   logic [3:0]  pstrb;
   logic        pready, pslverr, err, xact, dblk, bdone, ccmp, irq, xstop;
   logic        dma, cen, dir, mul, rts, rce, rid;
   logic [1:0]  acmd;
   int          err_total, checked, cyc, irq_n;

   hxs_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .data_line_cmd_block(dblk), .xfer_active(xact), .block_done(bdone),
      .cmd_complete(ccmp), .cmd_complete_sig_en(sig_en),
      .cmd_frame_arg(farg), .dma_en(dma), .blk_cnt_en(cen),
      .auto_cmd_en(acmd), .dir_read(dir), .multi_block(mul),
      .resp_check_type_sel(rts), .resp_check_en(rce), .resp_int_dis(rid),
      .xfer_stop(xstop), .cmd_complete_irq(irq));
   hxs_card_model card (.pclk(pclk), .presetn(presetn), .run(run),
      .fire(fire), .xfer_active(xact), .data_line_cmd_block(dblk),
      .block_done(bdone), .cmd_complete(ccmp));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (irq === 1'b1) irq_n++;
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got);
      checked++;
      if (got !== ex) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, rd);
   endtask
   task automatic irq_chk(input logic [31:0] md, input logic se, ex);
      int n0;
      apb(1'b1, HXS_OFF_XMODE, md);
      sig_en <= se;
      @(posedge pclk);
      n0 = irq_n;
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("irq", {31'h0, ex}, 32'(irq_n - n0));
   endtask

   initial begin
      {psel, penable, pwrite, run, fire, sig_en, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("count", HXS_OFF_BLK_CNT, 32'h0);
      chk("ready", 32'h1, {31'h0, pready});
      chk("slverr ok", 32'h0, {31'h0, err});
      rchk("arg", HXS_OFF_ARG, 32'h0);
      rchk("mode", HXS_OFF_XMODE, 32'h0);
      rchk("unmapped", 12'h010, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, HXS_OFF_ARG, 32'hA5C3_0F96);
      rchk("arg", HXS_OFF_ARG, 32'hA5C3_0F96);
      chk("frame", 32'hA5C3_0F96, farg);
      apb(1'b1, HXS_OFF_BLK_CNT, 32'h0000_FFFF);
      rchk("count max", HXS_OFF_BLK_CNT, 32'h0000_FFFF);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, HXS_OFF_XMODE, 32'h1 << i);
         rchk("mode", HXS_OFF_XMODE, (32'h1 << i) & 32'h01FF);
         chk("fields", (32'h1 << i) & 32'h01FF,
             {23'h0, rid, rce, rts, mul, dir, acmd, cen, dma});
      end
      apb(1'b1, HXS_OFF_BLK_CNT, 32'h3);
      apb(1'b1, HXS_OFF_XMODE, 32'h0023);
      run <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b1, HXS_OFF_XMODE, 32'h0010);
      apb(1'b1, HXS_OFF_BLK_CNT, 32'h7);
      rchk("mode locked", HXS_OFF_XMODE, 32'h0023);
      rchk("count locked", HXS_OFF_BLK_CNT, 32'h3);
      for (int n = 0; n < 80 && xstop !== 1'b1; n++) @(posedge pclk);
      chk("stop", 32'h1, {31'h0, xstop});
      rchk("count end", HXS_OFF_BLK_CNT, 32'h0);
      apb(1'b0, HXS_OFF_XMODE, 32'h0);
      saved = rd;
      run <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("stop off", 32'h0, {31'h0, xstop});
      apb(1'b1, HXS_OFF_XMODE, 32'h0);
      apb(1'b1, HXS_OFF_XMODE, saved);
      rchk("restored", HXS_OFF_XMODE, 32'h0023);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, HXS_OFF_BLK_CNT, 32'h2);
         apb(1'b1, HXS_OFF_XMODE, k == 0 ? 32'h0021 : 32'h0003);
         run <= 1'b1;
         repeat (40) @(posedge pclk);
         run <= 1'b0;
         repeat (2) @(posedge pclk);
         rchk("count held", HXS_OFF_BLK_CNT, 32'h2);
      end
      irq_chk(32'h0000, 1'b1, 1'b1);
      irq_chk(32'h0100, 1'b1, 1'b0);
      irq_chk(32'h0000, 1'b0, 1'b0);
      summarize();
   end
endmodule
